// *** tb_two_wire_bus_status_flags.sv ***
// Self-checking bench of the two-wire bus status flag block.
`timescale 1ns/1ns
module tb_two_wire_bus_status_flags;
   import tsf_pkg::*;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
   logic rvalid, rready, irq, scl_in, sda_in, master_active, master_sda_release;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic [DATA_W-1:0] wdata, rdata, d;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, resp;
   int n_errors, checked;
   // Address cases: control value, address byte, and whether it must match.
   logic [7:0] cfg [8] = '{8'h08, 8'h00, 8'h04, 8'h00, 8'h02, 8'h01, 8'h00, 8'h00};
   logic [7:0] adr [8] = '{8'h00, 8'h00, 8'h62, 8'h62, 8'h18, 8'h58, 8'h60, 8'h58};
   logic [7:0] hit = 8'h75;
   tsf_status_top uut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
      .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
      .rready, .scl_in, .sda_in, .master_active, .master_sda_release, .irq);
   tsf_i2c_model bus (.scl(scl_in), .sda(sda_in));
   always #20 aclk = ~aclk;
   // Compare one value and count it.
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   // Write one register; the response code lands in resp.
   task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] v);
      logic a;
      logic w;
      @(posedge aclk);
      awaddr <= {idx, 2'b00};
      wdata <= {24'h0, v};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      a = 1'b0;
      w = 1'b0;
      while (!(a && w)) begin
         @(posedge aclk);
         a = a | awready;
         w = w | wready;
         awvalid <= !a;
         wvalid <= !w;
      end
      do @(posedge aclk); while (bvalid !== 1'b1);
      bready <= 1'b1;
      @(posedge aclk);
      resp = bresp;
      bready <= 1'b0;
   endtask : wr
   // Read one register into d; ready is raised late to exercise the hold.
   task automatic rd(input logic [IDX_W-1:0] idx);
      @(posedge aclk);
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      rready <= 1'b1;
      @(posedge aclk);
      d = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask : rd
   task automatic sts(input string n, input logic [7:0] e);
      rd(IDX_STATUS);
      chk(n, d, {24'h0, e});
   endtask : sts
   task automatic results();
      $display("comparisons %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : results
   // Cut a hung run short well after the tests should have ended.
   initial begin
      #2000000;
      n_errors++;
      results();
   end
   // Main sequence of tests.
   initial begin
      aclk = 1'b0;
      aresetn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready, master_active, master_sda_release} = '0;
      {awaddr, araddr, wdata} = '0;
      wstrb = 4'hF;
      n_errors = 0;
      checked = 0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
      sts("status_reset", 8'h00);
      rd(4'h9);
      chk("rresp_unmapped", 32'(resp), 32'(RESP_SLVERR));
      wr(4'hA, 8'h55);
      chk("bresp_unmapped", 32'(resp), 32'(RESP_SLVERR));
      $display("test registers done");
      wr(IDX_INT_MASK, 8'h1F);
      wr(IDX_PRIMARY, 8'h50);
      wr(IDX_CTRL, 8'h00);
      bus.start();
      sts("busy_on_start", 8'h20);
      bus.send_byte(8'h50);
      sts("addressed_before_ack", 8'h60);
      chk("irq_raised", 32'(irq), 32'h1);
      bus.ack();
      sts("done_after_ack", 8'hE0);
      wr(IDX_CTRL, 8'h00);
      sts("ctrl_write_clears", 8'hA0);
      rd(IDX_DATA);
      sts("data_read_clears", 8'h20);
      bus.stop();
      sts("idle_after_stop", 8'h00);
      $display("test receive frame done");
      wr(IDX_SECOND, 8'h62);
      wr(IDX_RANGE, 8'h60);
      wr(IDX_INT_MASK, 8'h00);
      for (int i = 0; i < 8; i++) begin
         wr(IDX_CTRL, cfg[i]);
         bus.start();
         bus.send_byte(adr[i]);
         sts("address_match", {(i != 0), hit[i], 6'h20});
         bus.ack();
         bus.stop();
      end
      chk("irq_masked", 32'(irq), 32'h0);
      wr(IDX_INT_MASK, 8'h02);
      chk("irq_unmasked", 32'(irq), 32'h1);
      wr(IDX_INT_STATUS, 8'h1F);
      chk("irq_cleared", 32'(irq), 32'h0);
      $display("test address modes done");
      bus.start();
      bus.send_byte(8'h51);
      bus.ack();
      sts("target_transmit", 8'hE4);
      wr(IDX_CTRL, 8'h10);
      wr(IDX_DATA, 8'hA5);
      sts("data_write_clears", 8'h24);
      @(posedge aclk);
      master_active <= 1'b1;
      master_sda_release <= 1'b1;
      bus.send_byte(8'h00);
      @(posedge aclk);
      master_active <= 1'b0;
      master_sda_release <= 1'b0;
      bus.ack();
      sts("arb_lost", 8'hB4);
      wr(IDX_STATUS, 8'hEF);
      sts("status_read_only", 8'hB4);
      wr(IDX_STATUS, 8'h10);
      sts("arb_cleared", 8'hA4);
      bus.stop();
      sts("done_after_stop", 8'h84);
      $display("test transmit and arbitration done");
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      sts("status_after_reset", 8'h00);
      $display("test second reset done");
      results();
   end
endmodule : tb_two_wire_bus_status_flags

// *** tsf_bus_mon.sv ***
// Two-wire bus monitor: pin synchronisers, START/STOP and byte framing.
`timescale 1ns/1ns
module tsf_bus_mon
   import tsf_pkg::*;
(
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic scl_in,
   input  wire logic sda_in,
   tsf_mon_if.mon    mon
);
   logic       scl_meta_reg;
   logic       scl_sync_reg;
   logic       scl_prev_reg;
   logic       sda_meta_reg;
   logic       sda_sync_reg;
   logic       sda_prev_reg;
   logic [3:0] bit_cnt_reg;
   logic [7:0] shift_reg;
   logic       first_byte_reg;
   logic       in_frame_reg;
   logic       scl_rise;
   logic       scl_fall;

   // Two flip-flops per pin, then one more stage to find edges.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         scl_meta_reg <= 1'b1;
         scl_sync_reg <= 1'b1;
         scl_prev_reg <= 1'b1;
         sda_meta_reg <= 1'b1;
         sda_sync_reg <= 1'b1;
         sda_prev_reg <= 1'b1;
      end else begin
         scl_meta_reg <= scl_in;
         scl_sync_reg <= scl_meta_reg;
         scl_prev_reg <= scl_sync_reg;
         sda_meta_reg <= sda_in;
         sda_sync_reg <= sda_meta_reg;
         sda_prev_reg <= sda_sync_reg;
      end
   end

   // Data falling or rising while the clock stays high marks START or STOP.
   assign scl_rise      = scl_sync_reg & ~scl_prev_reg;
   assign scl_fall      = ~scl_sync_reg & scl_prev_reg;
   assign mon.start_det = scl_sync_reg & scl_prev_reg & sda_prev_reg & ~sda_sync_reg;
   assign mon.stop_det  = scl_sync_reg & scl_prev_reg & ~sda_prev_reg & sda_sync_reg;

   // Bits count on clock rises; the eighth fall ends data, the ninth ends ack.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bit_cnt_reg    <= 4'h0;
         shift_reg      <= 8'h00;
         first_byte_reg <= 1'b0;
         in_frame_reg   <= 1'b0;
      end else if (mon.start_det || mon.stop_det) begin
         bit_cnt_reg    <= 4'h0;
         first_byte_reg <= mon.start_det;
         in_frame_reg   <= mon.start_det;
      end else if (in_frame_reg && scl_rise) begin
         if (bit_cnt_reg < BIT_ACK) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
         end
         if (bit_cnt_reg < BIT_LAST_DATA) begin
            shift_reg <= {shift_reg[6:0], sda_sync_reg};
         end
      end else if (in_frame_reg && scl_fall && bit_cnt_reg == BIT_ACK) begin
         bit_cnt_reg    <= 4'h0;
         first_byte_reg <= 1'b0;
      end
   end

   // Byte-ready fires on the fall before the acknowledge slot.
   assign mon.byte_ready   = in_frame_reg & scl_fall & (bit_cnt_reg == BIT_LAST_DATA);
   assign mon.byte_done    = in_frame_reg & scl_fall & (bit_cnt_reg == BIT_ACK);
   assign mon.first_byte   = first_byte_reg;
   assign mon.rx_byte      = shift_reg;
   assign mon.sda_low_rise = scl_rise & ~sda_sync_reg;
endmodule : tsf_bus_mon

// *** tsf_chk.sv ***
// Checker of register bus handshakes and reset outputs at the top ports.
`timescale 1ns/1ns
module tsf_chk
   import tsf_pkg::*;
(
   input wire logic              aclk,
   input wire logic              aresetn,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic              awvalid,
   input wire logic              awready,
   input wire logic              wvalid,
   input wire logic              wready,
   input wire logic [1:0]        bresp,
   input wire logic              bvalid,
   input wire logic              bready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic              arvalid,
   input wire logic              arready,
   input wire logic [DATA_W-1:0] rdata,
   input wire logic [1:0]        rresp,
   input wire logic              rvalid,
   input wire logic              rready,
   input wire logic              irq
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // A write taken on both channels at one edge, and a taken read.
   sequence s_wr;
      awvalid && awready && wvalid && wready;
   endsequence
   sequence s_rd;
      arvalid && arready;
   endsequence
   // Answers come within the stated latency and carry the right code.
   AST_WR_OK: assert property (
      s_wr ##0 !awaddr[5] |-> ##[2:3] bvalid && bresp == RESP_OKAY) else $error("bad write answer");
   AST_WR_ERR: assert property (
      s_wr ##0 awaddr[5] |-> ##[2:3] bvalid && bresp == RESP_SLVERR) else $error("bad write error");
   AST_RD_OK: assert property (
      s_rd ##0 !araddr[5] |-> ##[2:3] rvalid && rresp == RESP_OKAY && rdata[31:8] == 24'h0)
      else $error("bad read answer");
   AST_RD_ERR: assert property (
      s_rd ##0 araddr[5] |-> ##[2:3] rvalid && rresp == RESP_SLVERR && rdata == 32'h0)
      else $error("bad read error");
   // Answers stand unchanged until taken, and block new requests meanwhile.
   AST_B_HOLD: assert property (
      bvalid && !bready |=> bvalid && $stable(bresp)) else $error("write answer dropped");
   AST_R_HOLD: assert property (
      rvalid && !rready |=> rvalid && $stable(rdata)) else $error("read answer dropped");
   AST_ONE_OUT: assert property (
      (bvalid |-> !awready && !wready) and (rvalid |-> !arready)) else $error("ready too early");
   AST_RST: assert property (disable iff (1'b0)
      !aresetn |=> !bvalid && !rvalid && !irq && awready && arready) else $error("reset state");
endmodule : tsf_chk

bind tsf_status_top tsf_chk chk_i (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wvalid, .wready,
   .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .irq);

// *** tsf_i2c_model.sv ***
// Behavioural two-wire bus master that frames bytes on the clock and data lines.
`timescale 1ns/1ns
module tsf_i2c_model (
   output logic scl,
   output logic sda
);
   // Both lines rest at their pull-up level while no frame runs.
   initial begin
      scl = 1'b1;
      sda = 1'b1;
   end
   // Data falls while the clock is high to open a frame.
   task automatic start();
      sda = 1'b0;
      #160;
      scl = 1'b0;
      #80;
   endtask : start
   // One bit: data changes only while the clock is low.
   task automatic clk_bit(input logic b);
      sda = b;
      #80;
      scl = 1'b1;
      #160;
      scl = 1'b0;
      #80;
   endtask : clk_bit
   task automatic send_byte(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) clk_bit(b[i]); // Most significant bit first.
      #160;
   endtask : send_byte
   // Acknowledge slot with the line released to its pull-up.
   task automatic ack();
      clk_bit(1'b1);
      #160;
   endtask : ack
   // Data rises while the clock is high to close the frame.
   task automatic stop();
      sda = 1'b0;
      #80;
      scl = 1'b1;
      #160;
      sda = 1'b1;
      #160;
   endtask : stop
endmodule : tsf_i2c_model

// *** tsf_mon_if.sv ***
// Interface carrying bus monitor events to the status core.
`timescale 1ns/1ns
interface tsf_mon_if;
   logic       start_det;
   logic       stop_det;
   logic       byte_ready;
   logic       byte_done;
   logic       first_byte;
   logic       sda_low_rise;
   logic [7:0] rx_byte;
   modport mon  (output start_det, stop_det, byte_ready, byte_done, first_byte,
                 sda_low_rise, rx_byte);
   modport core (input start_det, stop_det, byte_ready, byte_done, first_byte,
                 sda_low_rise, rx_byte);
endinterface : tsf_mon_if

// *** tsf_pkg.sv ***
// Shared constants for the two-wire bus status flag block.
// Functional notes
// - Transfer done flag sets after byte plus acknowledge.
// - Data access in current direction clears transfer done.
// - Primary or nonzero range address match sets addressed.
// - Enabled general call sets addressed flag.
// - Enabled second address match sets addressed flag.
// - Enabled alert response address sets addressed flag.
// - Enabled span between two addresses sets addressed.
// - Addressed flag rises before the address acknowledge.
// - Any control register write clears addressed flag.
// - Busy sets on START, clears on STOP.
// - Arbitration lost sets in hardware, write one clears.
// - Target direction follows received read/write bit.
package tsf_pkg;
   localparam int ADDR_W = 6;
   localparam int DATA_W = 32;
   localparam int IDX_W = 4;
   // Register indices; the byte address is four times the index.
   localparam logic [IDX_W-1:0] IDX_CTRL       = 4'h0;
   localparam logic [IDX_W-1:0] IDX_PRIMARY    = 4'h1;
   localparam logic [IDX_W-1:0] IDX_RANGE      = 4'h2;
   localparam logic [IDX_W-1:0] IDX_STATUS     = 4'h3;
   localparam logic [IDX_W-1:0] IDX_DATA       = 4'h4;
   localparam logic [IDX_W-1:0] IDX_SECOND     = 4'h5;
   localparam logic [IDX_W-1:0] IDX_INT_STATUS = 4'h6;
   localparam logic [IDX_W-1:0] IDX_INT_MASK   = 4'h7;
   // Status register field positions.
   localparam int ST_DONE_BIT = 7;
   localparam int ST_ADDR_BIT = 6;
   localparam int ST_BUSY_BIT = 5;
   localparam int ST_ARB_BIT  = 4;
   localparam int ST_DIR_BIT  = 2;
   // Control register field positions.
   localparam int CTRL_TX_BIT     = 4;
   localparam int CTRL_GC_BIT     = 3;
   localparam int CTRL_SECOND_BIT = 2;
   localparam int CTRL_ALERT_BIT  = 1;
   localparam int CTRL_RANGE_BIT  = 0;
   // Event positions shared by interrupt status and mask.
   localparam int EV_W     = 5;
   localparam int EV_DONE  = 0;
   localparam int EV_ADDR  = 1;
   localparam int EV_ARB   = 2;
   localparam int EV_START = 3;
   localparam int EV_STOP  = 4;
   // Reset values.
   localparam logic [7:0]      CTRL_RESET = 8'h00;
   localparam logic [7:0]      ADDR_RESET = 8'h00;
   localparam logic [7:0]      DATA_RESET = 8'h00;
   localparam logic [EV_W-1:0] MASK_RESET = 5'h00;
   // Special bus addresses, seven bits.
   localparam logic [6:0] GENERAL_CALL_ADDR = 7'h00;
   localparam logic [6:0] ALERT_ADDR        = 7'h0C;
   // Bit counter marks within a byte frame.
   localparam logic [3:0] BIT_LAST_DATA = 4'h8;
   localparam logic [3:0] BIT_ACK       = 4'h9;
   // Bus responses.
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : tsf_pkg

// *** tsf_status_top.sv ***
// Status flag core of the two-wire bus controller with its register slave.
`timescale 1ns/1ns
module tsf_status_top
   import tsf_pkg::*;
(
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [DATA_W-1:0] wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic              arvalid,
   output logic                   arready,
   output logic [DATA_W-1:0]      rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   input  wire logic              scl_in,
   input  wire logic              sda_in,
   input  wire logic              master_active,
   input  wire logic              master_sda_release,
   output logic                   irq
);
   tsf_mon_if mon_bus ();

   // Bus slave state.
   logic              awready_reg;
   logic              wready_reg;
   logic              bvalid_reg;
   logic [1:0]        bresp_reg;
   logic              arready_reg;
   logic              rvalid_reg;
   logic [1:0]        rresp_reg;
   logic [DATA_W-1:0] rdata_reg;
   logic [IDX_W-1:0]  wr_idx_reg;
   logic [7:0]        wdata_reg;
   logic              wlane_reg;
   logic [IDX_W-1:0]  rd_idx_reg;
   logic              rd_pend_reg;
   logic              wr_do;
   logic              rd_do;
   logic              wr_hit;

   // Software registers.
   logic [7:0]        first_control_reg;
   logic [7:0]        primary_address_reg;
   logic [7:0]        range_address_reg;
   logic [7:0]        second_address_reg;
   logic [7:0]        data_reg;
   logic [EV_W-1:0]   int_status_reg;
   logic [EV_W-1:0]   int_status_next;
   logic [EV_W-1:0]   int_mask_reg;
   logic              irq_reg;

   // Status flags.
   logic              transfer_done_flag_reg;
   logic              addressed_as_target_flag_reg;
   logic              bus_busy_flag_reg;
   logic              arbitration_lost_flag_reg;
   logic              target_direction_bit_reg;

   // Decoded conditions.
   logic [6:0]        call_addr;
   logic              primary_hit;
   logic              range_reg_hit;
   logic              general_call_hit;
   logic              second_hit;
   logic              alert_hit;
   logic              span_hit;
   logic              addr_hit;
   logic              arb_lost_evt;
   logic              data_access_clr;
   logic [EV_W-1:0]   events;
   logic [EV_W-1:0]   int_clr;
   logic [7:0]        status_byte;
   logic [DATA_W-1:0] rdata_next;
   logic              rd_mapped;

   // Pin synchronisers and byte framing.
   tsf_bus_mon u_bus_mon (
      .aclk    (aclk),
      .aresetn (aresetn),
      .scl_in  (scl_in),
      .sda_in  (sda_in),
      .mon     (mon_bus.mon)
   );

   // Write address and data are taken in either order, then acted on together.
   assign wr_do  = !awready_reg && !wready_reg && !bvalid_reg;
   assign wr_hit = wr_do && wlane_reg;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_reg <= 1'b1;
         wready_reg  <= 1'b1;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= RESP_OKAY;
         wr_idx_reg  <= 4'h0;
         wdata_reg   <= 8'h00;
         wlane_reg   <= 1'b0;
      end else begin
         if (awvalid && awready_reg) begin
            awready_reg <= 1'b0;
            wr_idx_reg  <= awaddr[ADDR_W-1:2];
         end
         if (wvalid && wready_reg) begin
            wready_reg <= 1'b0;
            wdata_reg  <= wdata[7:0];
            wlane_reg  <= wstrb[0];
         end
         if (wr_do) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= (wr_idx_reg <= IDX_INT_MASK) ? RESP_OKAY : RESP_SLVERR;
         end
         if (bvalid_reg && bready) begin
            bvalid_reg  <= 1'b0;
            awready_reg <= 1'b1;
            wready_reg  <= 1'b1;
         end
      end
   end

   // Reads answer one cycle after the address is taken.
   assign rd_do     = rd_pend_reg && !rvalid_reg;
   assign rd_mapped = rd_idx_reg <= IDX_INT_MASK;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_reg <= 1'b1;
         rvalid_reg  <= 1'b0;
         rresp_reg   <= RESP_OKAY;
         rdata_reg   <= 32'h0000_0000;
         rd_idx_reg  <= 4'h0;
         rd_pend_reg <= 1'b0;
      end else begin
         if (arvalid && arready_reg) begin
            arready_reg <= 1'b0;
            rd_pend_reg <= 1'b1;
            rd_idx_reg  <= araddr[ADDR_W-1:2];
         end
         if (rd_do) begin
            rvalid_reg  <= 1'b1;
            rd_pend_reg <= 1'b0;
            rdata_reg   <= rdata_next;
            rresp_reg   <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
         end
         if (rvalid_reg && rready) begin
            rvalid_reg  <= 1'b0;
            arready_reg <= 1'b1;
         end
      end
   end

   // Status byte always shows live flags; unused bits read zero.
   always_comb begin
      status_byte              = 8'h00;
      status_byte[ST_DONE_BIT] = transfer_done_flag_reg;
      status_byte[ST_ADDR_BIT] = addressed_as_target_flag_reg;
      status_byte[ST_BUSY_BIT] = bus_busy_flag_reg;
      status_byte[ST_ARB_BIT]  = arbitration_lost_flag_reg;
      status_byte[ST_DIR_BIT]  = target_direction_bit_reg;
   end

   // Read data mux; eight-bit registers sit in the low byte.
   always_comb begin
      rdata_next = 32'h0000_0000;
      unique case (rd_idx_reg)
         IDX_CTRL:       rdata_next[7:0] = first_control_reg;
         IDX_PRIMARY:    rdata_next[7:0] = primary_address_reg;
         IDX_RANGE:      rdata_next[7:0] = range_address_reg;
         IDX_STATUS:     rdata_next[7:0] = status_byte;
         IDX_DATA:       rdata_next[7:0] = data_reg;
         IDX_SECOND:     rdata_next[7:0] = second_address_reg;
         IDX_INT_STATUS: rdata_next[EV_W-1:0] = int_status_reg;
         IDX_INT_MASK:   rdata_next[EV_W-1:0] = int_mask_reg;
         default:        rdata_next = 32'h0000_0000;
      endcase
   end

   // Control and address registers written from software.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         first_control_reg   <= CTRL_RESET;
         primary_address_reg <= ADDR_RESET;
         range_address_reg   <= ADDR_RESET;
         second_address_reg  <= ADDR_RESET;
         int_mask_reg        <= MASK_RESET;
      end else if (wr_hit) begin
         if (wr_idx_reg == IDX_CTRL) begin
            first_control_reg <= wdata_reg;
         end
         if (wr_idx_reg == IDX_PRIMARY) begin
            primary_address_reg <= wdata_reg;
         end
         if (wr_idx_reg == IDX_RANGE) begin
            range_address_reg <= wdata_reg;
         end
         if (wr_idx_reg == IDX_SECOND) begin
            second_address_reg <= wdata_reg;
         end
         if (wr_idx_reg == IDX_INT_MASK) begin
            int_mask_reg <= wdata_reg[EV_W-1:0];
         end
      end
   end

   // Data register holds the last received byte or the byte software wrote.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         data_reg <= DATA_RESET;
      end else if (wr_hit && wr_idx_reg == IDX_DATA) begin
         data_reg <= wdata_reg;
      end else if (mon_bus.byte_ready && !first_control_reg[CTRL_TX_BIT]) begin
         data_reg <= mon_bus.rx_byte;
      end
   end

   // Calling address comparisons against every enabled source.
   assign call_addr        = mon_bus.rx_byte[7:1];
   assign primary_hit      = (call_addr != GENERAL_CALL_ADDR)
                             && (call_addr == primary_address_reg[7:1]);
   assign range_reg_hit    = (range_address_reg[7:1] != 7'h00)
                             && (call_addr == range_address_reg[7:1]);
   assign general_call_hit = first_control_reg[CTRL_GC_BIT]
                             && (call_addr == GENERAL_CALL_ADDR)
                             && !mon_bus.rx_byte[0];
   assign second_hit       = first_control_reg[CTRL_SECOND_BIT]
                             && (call_addr == second_address_reg[7:1]);
   assign alert_hit        = first_control_reg[CTRL_ALERT_BIT]
                             && (call_addr == ALERT_ADDR);
   assign span_hit         = first_control_reg[CTRL_RANGE_BIT]
                             && (call_addr >= primary_address_reg[7:1])
                             && (call_addr <= range_address_reg[7:1]);

   // Matching is judged on the fall that ends the eighth bit, ahead of ack.
   assign addr_hit = mon_bus.byte_ready && mon_bus.first_byte
                     && (primary_hit || range_reg_hit || general_call_hit
                         || second_hit || alert_hit || span_hit);

   // Arbitration is lost when our released data line reads low at a clock rise.
   assign arb_lost_evt = master_active && master_sda_release && mon_bus.sda_low_rise;

   // A data access in the selected direction consumes the finished byte.
   assign data_access_clr = first_control_reg[CTRL_TX_BIT]
                            ? (wr_hit && wr_idx_reg == IDX_DATA)
                            : (rd_do && rd_idx_reg == IDX_DATA);

   // Transfer done: the set wins over a clear in the same cycle.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         transfer_done_flag_reg <= 1'b0;
      end else if (mon_bus.byte_done) begin
         transfer_done_flag_reg <= 1'b1;
      end else if (data_access_clr) begin
         transfer_done_flag_reg <= 1'b0;
      end
   end

   // Addressed flag and target direction, latched together on a match.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         addressed_as_target_flag_reg <= 1'b0;
         target_direction_bit_reg     <= 1'b0;
      end else if (addr_hit) begin
         addressed_as_target_flag_reg <= 1'b1;
         target_direction_bit_reg     <= mon_bus.rx_byte[0];
      end else if (wr_do && wr_idx_reg == IDX_CTRL) begin
         addressed_as_target_flag_reg <= 1'b0;
      end
   end

   // Bus occupancy follows START and STOP whatever our role.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bus_busy_flag_reg <= 1'b0;
      end else if (mon_bus.start_det) begin
         bus_busy_flag_reg <= 1'b1;
      end else if (mon_bus.stop_det) begin
         bus_busy_flag_reg <= 1'b0;
      end
   end

   // Arbitration lost: sticky, write one to clear, the set wins.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arbitration_lost_flag_reg <= 1'b0;
      end else if (arb_lost_evt) begin
         arbitration_lost_flag_reg <= 1'b1;
      end else if (wr_hit && wr_idx_reg == IDX_STATUS && wdata_reg[ST_ARB_BIT]) begin
         arbitration_lost_flag_reg <= 1'b0;
      end
   end

   // Interrupt events and their write-one clears.
   always_comb begin
      events           = '0;
      events[EV_DONE]  = mon_bus.byte_done;
      events[EV_ADDR]  = addr_hit;
      events[EV_ARB]   = arb_lost_evt;
      events[EV_START] = mon_bus.start_det;
      events[EV_STOP]  = mon_bus.stop_det;
   end

   assign int_clr = (wr_hit && wr_idx_reg == IDX_INT_STATUS)
                    ? wdata_reg[EV_W-1:0] : '0;

   // Each sticky bit sets on its event, which wins over a clear.
   for (genvar i = 0; i < EV_W; i++) begin : g_int
      assign int_status_next[i] = events[i] | (int_status_reg[i] & ~int_clr[i]);
   end

   // Interrupt status and the level output driven from a flop.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         int_status_reg <= '0;
         irq_reg        <= 1'b0;
      end else begin
         int_status_reg <= int_status_next;
         irq_reg        <= |(int_status_next & int_mask_reg);
      end
   end

   // Top outputs straight from flip-flops.
   assign awready = awready_reg;
   assign wready  = wready_reg;
   assign bvalid  = bvalid_reg;
   assign bresp   = bresp_reg;
   assign arready = arready_reg;
   assign rvalid  = rvalid_reg;
   assign rresp   = rresp_reg;
   assign rdata   = rdata_reg;
   assign irq     = irq_reg;
endmodule : tsf_status_top
